/* verilog/ebr_pkg.sv */
// shared constants of the embedded block ram
// assumes nothing beyond a SystemVerilog compiler
package ebr_pkg;
    localparam int EBR_DATA_BITS  = 4096;
    localparam int EBR_TOTAL_BITS = 4608;
    localparam int EBR_LANE_BITS  = 9;
    localparam int EBR_BYTE_BITS  = 8;
    localparam int EBR_LANES      = 512;
    localparam int EBR_ADDR_W     = 12;
    localparam int EBR_BE_W       = 4;
    localparam int EBR_MAX_W      = 36;
    localparam int EBR_MIN_DEPTH  = 128;
    localparam int EBR_MAX_DEPTH  = 4096;
endpackage : ebr_pkg

/* verilog/ebr_ram.sv */
// true dual-port embedded ram block with byte masking and output registers
// assumes on-chip user logic on CLK drives every port input
// What this block does
// - stores 4,096 data bits plus parity positions, 4,608 bits in all.
// - port shapes from 4K x 1 through 512 x 9 to 128 x 36.
// - both ports act in one cycle: read plus write, two reads, two writes.
// - per-byte mask inputs stop masked lanes of a write from being stored.
// - masked-out bytes keep old value; all-ones mask leaves write strobe alone.
// - contents preloadable at configuration, for ram and rom use.
// - a port's clock enable low freezes only that port's registers and array writes; the clears still act.
// - input registers have no asynchronous clear; output registers do.
// - registers reset by power-up, output clear, or chip-wide clear only.
// - asynchronous output clear zeroes output registers at once.
// - a port reading the address it writes returns the new data.
// - a port reading what the other port writes returns old data.
// - the two ports may use different word widths.
// - address hold high recirculates the stored address instead of loading.
`timescale 1ns/1ps
module ebr_ram
    import ebr_pkg::*;
#(
    parameter int                         A_W        = 36,
    parameter int                         B_W        = 36,
    parameter bit                         A_WRITABLE = 1'b1,
    parameter bit                         B_WRITABLE = 1'b1,
    parameter bit                         A_OUT_REG  = 1'b1,
    parameter bit                         B_OUT_REG  = 1'b1,
    parameter logic [EBR_TOTAL_BITS-1:0]  INIT_BITS  = '0
) (
    // clock and resets
    input  wire logic                  CLK,
    input  wire logic                  RST,
    input  wire logic                  CHIP_WIDE_CLEAR,
    // port a
    input  wire logic                  A_CE,
    input  wire logic [EBR_ADDR_W-1:0] A_ADDR,
    input  wire logic                  A_ADDR_HOLD,
    input  wire logic                  A_WE,
    input  wire logic [EBR_BE_W-1:0]   A_BE,
    input  wire logic [A_W-1:0]        A_DATA,
    input  wire logic                  A_OUT_CLEAR,
    output logic      [A_W-1:0]        A_Q,
    // port b
    input  wire logic                  B_CE,
    input  wire logic [EBR_ADDR_W-1:0] B_ADDR,
    input  wire logic                  B_ADDR_HOLD,
    input  wire logic                  B_WE,
    input  wire logic [EBR_BE_W-1:0]   B_BE,
    input  wire logic [B_W-1:0]        B_DATA,
    input  wire logic                  B_OUT_CLEAR,
    output logic      [B_W-1:0]        B_Q
);
    // nine-bit lanes; words of 8, 16, 32 or narrower leave bit 8 of each lane unused
    logic [EBR_LANE_BITS-1:0] mem [0:EBR_LANES-1];

    function automatic int lane_w(input int w);
        return (w % EBR_LANE_BITS == 0) ? EBR_LANE_BITS : EBR_BYTE_BITS;
    endfunction : lane_w

    function automatic int depth_of(input int w);
        return ((lane_w(w) == EBR_LANE_BITS) ? EBR_TOTAL_BITS : EBR_DATA_BITS) / w;
    endfunction : depth_of

    function automatic int pos_of(input int addr, input int w, input int i);
        return (addr % depth_of(w)) * w + i;
    endfunction : pos_of

    // each port maps its word onto the same lanes by its own width
    function automatic logic [EBR_MAX_W-1:0] read_word(input int addr, input int w);
        logic [EBR_MAX_W-1:0] r;
        int p;
        r = '0;
        for (int i = 0; i < w; i++) begin
            p = pos_of(addr, w, i);
            r[i] = mem[p / lane_w(w)][p % lane_w(w)];
        end
        return r;
    endfunction : read_word

    function automatic logic [EBR_MAX_W-1:0] merge(input logic [EBR_MAX_W-1:0] old_w,
                                                  input logic [EBR_MAX_W-1:0] new_w,
                                                  input logic [EBR_BE_W-1:0]  be,
                                                  input int                   w);
        logic [EBR_MAX_W-1:0] r;
        r = old_w;
        for (int i = 0; i < w; i++) begin
            if (be[i / lane_w(w)]) begin
                r[i] = new_w[i];
            end
        end
        return r;
    endfunction : merge

    // registered state
    logic [EBR_ADDR_W-1:0] a_addr;
    logic [EBR_ADDR_W-1:0] b_addr;
    logic [A_W-1:0]        a_rd;
    logic [B_W-1:0]        b_rd;
    logic [A_W-1:0]        a_q;
    logic [B_W-1:0]        b_q;

    // address hold recirculates the stored address
    wire logic [EBR_ADDR_W-1:0] a_eff = A_ADDR_HOLD ? a_addr : A_ADDR;
    wire logic [EBR_ADDR_W-1:0] b_eff = B_ADDR_HOLD ? b_addr : B_ADDR;
    wire logic                  a_wr  = A_CE && A_WE && A_WRITABLE;
    wire logic                  b_wr  = B_CE && B_WE && B_WRITABLE;

    // process, not assign: an assign would miss array writes read inside the function
    logic [EBR_MAX_W-1:0] a_old;
    logic [EBR_MAX_W-1:0] b_old;
    always_comb begin
        a_old = read_word(int'(a_eff), A_W);
        b_old = read_word(int'(b_eff), B_W);
    end
    wire logic [EBR_MAX_W-1:0] a_in  = EBR_MAX_W'(A_DATA);
    wire logic [EBR_MAX_W-1:0] b_in  = EBR_MAX_W'(B_DATA);
    // same port sees its own write; the other port's write is not merged in
    wire logic [EBR_MAX_W-1:0] next_a_rd = a_wr ? merge(a_old, a_in, A_BE, A_W) : a_old;
    wire logic [EBR_MAX_W-1:0] next_b_rd = b_wr ? merge(b_old, b_in, B_BE, B_W) : b_old;
    wire logic                 clr_all   = RST || CHIP_WIDE_CLEAR;

    // preload at configuration; rom ports never write
    initial begin
        for (int p = 0; p < EBR_TOTAL_BITS; p++) begin
            mem[p / EBR_LANE_BITS][p % EBR_LANE_BITS] = INIT_BITS[p];
        end
    end

    // array is untouched by any reset; colliding writes let port b win
    always @(posedge CLK) begin
        if (a_wr) begin
            for (int i = 0; i < A_W; i++) begin
                if (A_BE[i / lane_w(A_W)]) begin
                    mem[pos_of(int'(a_eff), A_W, i) / lane_w(A_W)]
                       [pos_of(int'(a_eff), A_W, i) % lane_w(A_W)] <= A_DATA[i];
                end
            end
        end
        if (b_wr) begin
            for (int i = 0; i < B_W; i++) begin
                if (B_BE[i / lane_w(B_W)]) begin
                    mem[pos_of(int'(b_eff), B_W, i) / lane_w(B_W)]
                       [pos_of(int'(b_eff), B_W, i) % lane_w(B_W)] <= B_DATA[i];
                end
            end
        end
    end

    // input and read registers: synchronous clears only
    always_ff @(posedge CLK) begin
        if (clr_all) begin
            a_addr <= '0;
            a_rd   <= '0;
        end else if (A_CE) begin
            a_addr <= a_eff;
            a_rd   <= next_a_rd[A_W-1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (clr_all) begin
            b_addr <= '0;
            b_rd   <= '0;
        end else if (B_CE) begin
            b_addr <= b_eff;
            b_rd   <= next_b_rd[B_W-1:0];
        end
    end

    // output registers take the asynchronous clear
    always_ff @(posedge CLK or posedge A_OUT_CLEAR) begin
        if (A_OUT_CLEAR) begin
            a_q <= '0;
        end else if (clr_all) begin
            a_q <= '0;
        end else if (A_CE) begin
            a_q <= a_rd;
        end
    end

    always_ff @(posedge CLK or posedge B_OUT_CLEAR) begin
        if (B_OUT_CLEAR) begin
            b_q <= '0;
        end else if (clr_all) begin
            b_q <= '0;
        end else if (B_CE) begin
            b_q <= b_rd;
        end
    end

    // flow-through output skips the pipeline stage and so its clear
    assign A_Q = A_OUT_REG ? a_q : a_rd;
    assign B_Q = B_OUT_REG ? b_q : b_rd;

    sequence s_a_full_write;
        A_CE && A_WE && (A_BE == '1) && !(B_CE && B_WE);
    endsequence

    sequence s_b_pure_read;
        B_CE && !B_WE && !CHIP_WIDE_CLEAR;
    endsequence

    sequence s_a_mask_none;
        A_CE && A_WE && (A_BE == '0) && !(B_CE && B_WE) && !CHIP_WIDE_CLEAR;
    endsequence

    sequence s_a_hold_read;
        A_CE && !A_WE && A_ADDR_HOLD && !CHIP_WIDE_CLEAR;
    endsequence

    a_ce_freeze: assert property (@(posedge CLK) disable iff (RST)
        (!A_CE && !CHIP_WIDE_CLEAR) |=> $stable(a_rd) && $stable(a_addr))
        else $error("port a changed with clock enable low");
    a_addr_hold: assert property (@(posedge CLK) disable iff (RST)
        (A_CE && A_ADDR_HOLD && !CHIP_WIDE_CLEAR) |=> (a_addr == $past(a_addr)))
        else $error("held address did not recirculate");
    a_same_new: assert property (@(posedge CLK) disable iff (RST)
        (s_a_full_write and (A_WRITABLE && !CHIP_WIDE_CLEAR)) |=> (a_rd == $past(A_DATA)))
        else $error("same-port read did not return new data");
    a_mixed_old: assert property (@(posedge CLK) disable iff (RST)
        s_b_pure_read |=> (b_rd == $past(b_old[B_W-1:0])))
        else $error("mixed-port read did not return old data");
    a_mask_keep: assert property (@(posedge CLK) disable iff (RST)
        (s_a_mask_none ##1 s_a_hold_read) |=> $stable(a_rd))
        else $error("masked write changed memory");
    a_out_clear: assert property (@(posedge CLK)
        (A_OUT_CLEAR && A_OUT_REG) |-> (A_Q == '0))
        else $error("output clear did not zero port a");
    a_power_up: assert property (@(posedge CLK)
        RST |=> (a_rd == '0) && (b_rd == '0) && (a_q == '0) && (b_q == '0))
        else $error("outputs not cleared after reset");
    a_chip_clear: assert property (@(posedge CLK) disable iff (RST)
        CHIP_WIDE_CLEAR |=> (a_rd == '0) && (b_addr == '0))
        else $error("chip-wide clear missed a register");
    a_out_pipe: assert property (@(posedge CLK) disable iff (RST || B_OUT_CLEAR)
        (B_CE && !CHIP_WIDE_CLEAR && B_OUT_REG) |=> (B_Q == $past(b_rd)))
        else $error("port b output register did not follow read data");
endmodule : ebr_ram

/* sim/ebr_user.sv */
// user logic model for port b: second ram port driver for the bench
// assumes every call lands at a rising CLK edge from the bench
`timescale 1ns/1ps
module ebr_user
    import ebr_pkg::*;
(
    // port b drive
    output logic                  B_CE,
    output logic [EBR_ADDR_W-1:0] B_ADDR,
    output logic                  B_ADDR_HOLD,
    output logic                  B_WE,
    output logic [EBR_BE_W-1:0]   B_BE,
    output logic [EBR_MAX_W-1:0]  B_DATA,
    output logic                  B_OUT_CLEAR
);
    // no parity or fifo bookkeeping is needed by these plain accesses
    initial begin
        B_CE        = 1'b0;
        B_ADDR      = '0;
        B_ADDR_HOLD = 1'b0;
        B_WE        = 1'b0;
        B_BE        = '1;
        B_DATA      = '0;
        B_OUT_CLEAR = 1'b0;
    end
    // data scrambled while not writing so stale values never look valid
    task b_drive(input logic ce, input logic we, input logic [EBR_ADDR_W-1:0] ad,
                 input logic [EBR_MAX_W-1:0] d);
        B_CE   <= ce;
        B_WE   <= we;
        B_ADDR <= ad;
        B_DATA <= we ? d : ~B_DATA;
    endtask : b_drive
endmodule : ebr_user

/* sim/tb_embedded_block_ram.sv */
// self-checking bench: a 36/36 block, and a 36/9 block with flow-through a and rom b
// assumes ebr_user drives port b while the bench drives port a directly
`timescale 1ns/1ps
module tb_embedded_block_ram
    import ebr_pkg::*;
;
    logic                  clk;
    logic                  rst;
    logic                  cwc;
    logic                  a_ce;
    logic                  a_we;
    logic                  a_hold;
    logic                  a_oclr;
    logic [EBR_ADDR_W-1:0] a_addr;
    logic [EBR_BE_W-1:0]   a_be;
    logic [EBR_MAX_W-1:0]  a_data;
    logic [EBR_MAX_W-1:0]  a_q;
    logic [EBR_MAX_W-1:0]  b_q;
    logic [EBR_MAX_W-1:0]  mix_a_q;
    logic [EBR_LANE_BITS-1:0] mix_b_q;
    logic                  b_ce;
    logic                  b_hold;
    logic                  b_we;
    logic                  b_oclr;
    logic [EBR_ADDR_W-1:0] b_addr;
    logic [EBR_BE_W-1:0]   b_be;
    logic [EBR_MAX_W-1:0]  b_data;
    int                    n_mismatch  = 0;
    int                    checks_done = 0;
    int                    cycles      = 0;

    ebr_ram #(.INIT_BITS(4608'h0a5a5a5a5_123456789)) dut_u (
        .CLK(clk), .RST(rst), .CHIP_WIDE_CLEAR(cwc),
        .A_CE(a_ce), .A_ADDR(a_addr), .A_ADDR_HOLD(a_hold), .A_WE(a_we), .A_BE(a_be),
        .A_DATA(a_data), .A_OUT_CLEAR(a_oclr), .A_Q(a_q),
        .B_CE(b_ce), .B_ADDR(b_addr), .B_ADDR_HOLD(b_hold), .B_WE(b_we), .B_BE(b_be),
        .B_DATA(b_data), .B_OUT_CLEAR(b_oclr), .B_Q(b_q));
    ebr_user prt_u (.B_CE(b_ce), .B_ADDR(b_addr), .B_ADDR_HOLD(b_hold), .B_WE(b_we),
        .B_BE(b_be), .B_DATA(b_data), .B_OUT_CLEAR(b_oclr));
    // 9-bit word 4n+1 is lane 1 of 36-bit word n, so both blocks see the same words
    ebr_ram #(.B_W(EBR_LANE_BITS), .B_WRITABLE(1'b0), .A_OUT_REG(1'b0), .B_OUT_REG(1'b0),
              .INIT_BITS(4608'h0a5a5a5a5_123456789)) mix_u (
        .CLK(clk), .RST(rst), .CHIP_WIDE_CLEAR(cwc),
        .A_CE(a_ce), .A_ADDR(a_addr), .A_ADDR_HOLD(a_hold), .A_WE(a_we), .A_BE(a_be),
        .A_DATA(a_data), .A_OUT_CLEAR(a_oclr), .A_Q(mix_a_q),
        .B_CE(b_ce), .B_ADDR({b_addr[EBR_ADDR_W-3:0], 2'h1}),
        .B_ADDR_HOLD(b_hold), .B_WE(b_we), .B_BE(b_be),
        .B_DATA(b_data[EBR_LANE_BITS-1:0]), .B_OUT_CLEAR(b_oclr), .B_Q(mix_b_q));

    task tally_and_finish;
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one access on each port; results settle on Q two edges later
    task op(input logic aw, input logic [11:0] aa, input logic [35:0] ad,
            input logic [3:0] ab, input logic ah, input logic bw, input logic [11:0] ba,
            input logic [35:0] bd);
        @(posedge clk);
        a_ce   <= 1'b1;
        a_we   <= aw;
        a_addr <= aa;
        a_data <= ad;
        a_be   <= ab;
        a_hold <= ah;
        prt_u.b_drive(1'b1, bw, ba, bd);
        @(posedge clk);
        a_we <= 1'b0;
        prt_u.b_drive(1'b1, 1'b0, ba, bd);
        @(posedge clk);
        a_ce   <= 1'b0;
        a_hold <= 1'b0;
        prt_u.b_drive(1'b0, 1'b0, ba, bd);
        #1;
    endtask : op

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 500) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        rst = 1'b1; cwc = 1'b0; a_ce = 1'b0; a_we = 1'b0; a_hold = 1'b0; a_oclr = 1'b0;
        a_addr = '0; a_be = '1; a_data = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("a_q after reset", 36'h0, a_q);
        op(1'h0, 12'h000, 36'h0, 4'hf, 1'h0, 1'h0, 12'h001, 36'h0);
        chk("a_q preload", 36'h123456789, a_q);
        chk("b_q preload", 36'h0a5a5a5a5, b_q);
        chk("mix b_q preload lane", 36'h0d2, EBR_MAX_W'(mix_b_q));
        op(1'h1, 12'h005, 36'hfffffffff, 4'hf, 1'h0, 1'h1, 12'h006, 36'h111111111);
        chk("a_q new data", 36'hfffffffff, a_q);
        chk("b_q new data", 36'h111111111, b_q);
        chk("mix a_q flow-through", 36'hfffffffff, mix_a_q);
        chk("mix b_q rom ignores write", 36'h0, EBR_MAX_W'(mix_b_q));
        op(1'h1, 12'h005, 36'h0, 4'h5, 1'h0, 1'h0, 12'h005, 36'h0);
        chk("a_q masked write", 36'hff803fe00, a_q);
        chk("b_q mixed port", 36'hfffffffff, b_q);
        chk("mix b_q masked lane kept", 36'h1ff, EBR_MAX_W'(mix_b_q));
        @(posedge clk);
        a_we   <= 1'b1;
        a_data <= '0;
        a_be   <= '1;
        @(posedge clk);
        a_we <= 1'b0;
        #1;
        chk("a_q frozen", 36'hff803fe00, a_q);
        op(1'h0, 12'h005, 36'h0, 4'hf, 1'h0, 1'h0, 12'h006, 36'h0);
        chk("a_q after gated write", 36'hff803fe00, a_q);
        op(1'h1, 12'h009, 36'h0, 4'h0, 1'h1, 1'h0, 12'h005, 36'h0);
        chk("a_q address hold", 36'hff803fe00, a_q);
        @(posedge clk);
        a_oclr <= 1'b1;
        #1;
        chk("a_q output clear", 36'h0, a_q);
        chk("mix a_q flow-through kept", 36'hff803fe00, mix_a_q);
        @(posedge clk);
        a_oclr <= 1'b0;
        cwc    <= 1'b1;
        @(posedge clk);
        cwc <= 1'b0;
        #1;
        chk("b_q chip wide clear", 36'h0, b_q);
        chk("mix b_q chip wide clear", 36'h0, EBR_MAX_W'(mix_b_q));
        chk("mix a_q chip wide clear", 36'h0, mix_a_q);
        tally_and_finish();
    end
endmodule : tb_embedded_block_ram
